// ==== design/key_position_encode.sv ====
// Row nibble to key position code encoder
`timescale 1ns/1ps
`default_nettype none
`include "keyboard_matrix_scanner_defs.svh"
module key_position_encode
  import keyboard_matrix_scanner_pkg::*;
(
  input  wire logic [3:0] row_act,
  output var  key_code_t  code
);
  always_comb
  begin
    case (row_act)
      `KMS_CODE_NONE: code = `KMS_CODE_NONE;
      `KMS_ROW_BIT0:  code = `KMS_CODE_POS1;
      `KMS_ROW_BIT1:  code = `KMS_CODE_POS2;
      `KMS_ROW_BIT2:  code = `KMS_CODE_POS3;
      `KMS_ROW_BIT3:  code = `KMS_CODE_POS4;
      default:        code = `KMS_CODE_MULTI;
    endcase
  end
endmodule : key_position_encode
`default_nettype wire

// ==== design/keyboard_matrix_scanner.sv ====
// Keyboard matrix scanner: walking-zero column drive, row encode, debounce
`timescale 1ns/1ps
`default_nettype none
`include "keyboard_matrix_scanner_defs.svh"
module keyboard_matrix_scanner
  import keyboard_matrix_scanner_pkg::*;
#(
  parameter int unsigned N_COLS      = `KMS_NUM_COLS,
  parameter int unsigned DEB_SCANS   = `KMS_DEBOUNCE_SCANS,
  parameter int unsigned SCAN_CYCLES = `KMS_CLK_HZ / `KMS_SCAN_RATE_HZ,
  parameter int unsigned COL_W       = $clog2(N_COLS)
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              scan_en,
  input  wire logic              precoded_en,
  input  wire logic [3:0]        row_n,
  output var  logic [N_COLS-1:0] col_oe,
  output var  logic [COL_W-1:0]  digit_sel,
  output var  logic              key_flag,
  output var  logic              key_valid,
  output var  logic              key_down,
  output var  key_code_t         key_code,
  output var  logic [COL_W-1:0]  key_col
);
  localparam int unsigned COL_DWELL  = (SCAN_CYCLES / N_COLS < 1) ? 1 : SCAN_CYCLES / N_COLS;
  localparam logic [31:0] DWELL_LAST = 32'(COL_DWELL - 1);
  localparam int unsigned CNT_W      = $clog2(DEB_SCANS + 1);
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEB_SCANS - 1);
  localparam logic [CNT_W-1:0] DEB_MAX  = CNT_W'(DEB_SCANS);
  localparam logic [COL_W-1:0] COL_LAST = COL_W'(N_COLS - 1);

  logic [3:0]        row_meta_ff;
  logic [3:0]        row_sync_ff;
  scan_state_e       state_ff;
  logic [31:0]       dwell_ff;
  logic [COL_W-1:0]  col_idx_ff;
  logic [N_COLS-1:0] col_oe_ff;
  logic              scan_hit_ff;
  logic              key_flag_ff;
  logic              key_valid_ff;
  logic              key_down_ff;
  key_code_t         key_code_ff;
  logic [COL_W-1:0]  key_col_ff;
  key_code_t         last_code_ff [N_COLS];
  logic [CNT_W-1:0]  deb_cnt_ff   [N_COLS];

  logic      dwell_end;
  logic      sample;
  logic      any_row;
  logic [3:0] row_act;
  key_code_t enc_code;
  key_code_t obs_code;

  // Pressed key pulls its row low through the low column
  assign row_act   = ~row_sync_ff;
  assign any_row   = |row_act;
  assign dwell_end = (dwell_ff == DWELL_LAST);
  assign sample    = (state_ff == ST_SCAN) && dwell_end;

  key_position_encode u_encode (
    .row_act (row_act),
    .code    (enc_code)
  );

  // Precoded keyboards present their code on the row pins directly
  assign obs_code = precoded_en ? row_act : enc_code;

  // Row pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      row_meta_ff <= 4'hf;
      row_sync_ff <= 4'hf;
    end
    else
    begin
      row_meta_ff <= row_n;
      row_sync_ff <= row_meta_ff;
    end
  end

  // Column walk. Each column is held a full dwell so rows settle before the
  // sample at its end; the dwell also sets the full-scan rate.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= ST_PROBE;
      dwell_ff    <= 32'h0000_0000;
      col_idx_ff  <= '0;
      col_oe_ff   <= '1;
      scan_hit_ff <= 1'b0;
    end
    else if (!scan_en)
    begin
      // Driver disabled: every column low, all keys seen together
      state_ff    <= ST_PROBE;
      dwell_ff    <= 32'h0000_0000;
      col_idx_ff  <= '0;
      col_oe_ff   <= '1;
      scan_hit_ff <= 1'b0;
    end
    else if (!dwell_end)
    begin
      dwell_ff <= dwell_ff + 32'h0000_0001;
    end
    else
    begin
      dwell_ff <= 32'h0000_0000;
      case (state_ff)
        ST_PROBE:
        begin
          if (any_row)
          begin
            state_ff    <= ST_SCAN;
            col_idx_ff  <= '0;
            col_oe_ff   <= {{(N_COLS-1){1'b0}}, 1'b1};
            scan_hit_ff <= 1'b0;
          end
        end
        ST_SCAN:
        begin
          if (col_idx_ff == COL_LAST)
          begin
            // A whole scan with nothing pressed falls back to the cheap probe
            if (!scan_hit_ff && !any_row)
            begin
              state_ff  <= ST_PROBE;
              col_oe_ff <= '1;
            end
            else
            begin
              col_oe_ff <= {{(N_COLS-1){1'b0}}, 1'b1};
            end
            col_idx_ff  <= '0;
            scan_hit_ff <= 1'b0;
          end
          else
          begin
            col_idx_ff  <= col_idx_ff + COL_W'(1);
            col_oe_ff   <= {col_oe_ff[N_COLS-2:0], 1'b0};
            scan_hit_ff <= scan_hit_ff | any_row;
          end
        end
        default:
        begin
          state_ff  <= ST_PROBE;
          col_oe_ff <= '1;
        end
      endcase
    end
  end

  // Per-column debounce: a code must repeat on DEB_SCANS consecutive scans
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < N_COLS; i++)
      begin
        last_code_ff[i] <= `KMS_CODE_NONE;
        deb_cnt_ff[i]   <= '0;
      end
    end
    else if (sample)
    begin
      if (obs_code == last_code_ff[col_idx_ff])
      begin
        if (deb_cnt_ff[col_idx_ff] != DEB_MAX)
        begin
          deb_cnt_ff[col_idx_ff] <= deb_cnt_ff[col_idx_ff] + CNT_W'(1);
        end
      end
      else
      begin
        last_code_ff[col_idx_ff] <= obs_code;
        deb_cnt_ff[col_idx_ff]   <= CNT_W'(1);
      end
    end
  end

  // Accepted-key report
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_valid_ff <= 1'b0;
      key_down_ff  <= 1'b0;
      key_code_ff  <= `KMS_CODE_NONE;
      key_col_ff   <= '0;
    end
    else
    begin
      key_valid_ff <= 1'b0;
      if (sample && obs_code == last_code_ff[col_idx_ff]
          && deb_cnt_ff[col_idx_ff] == DEB_LAST)
      begin
        if (obs_code != `KMS_CODE_NONE)
        begin
          key_valid_ff <= 1'b1;
          key_down_ff  <= 1'b1;
          key_code_ff  <= obs_code;
          key_col_ff   <= col_idx_ff;
        end
        else if (col_idx_ff == key_col_ff)
        begin
          key_down_ff <= 1'b0;
        end
      end
      else if (state_ff == ST_PROBE && dwell_end && !any_row)
      begin
        key_down_ff <= 1'b0;
      end
    end
  end

  // Any-key detect, read from the row lines
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      key_flag_ff <= 1'b0;
    end
    else
    begin
      key_flag_ff <= any_row;
    end
  end

  // Open-drain columns: released lines float high, so a key shorting
  // two columns can only pull the pair low
  assign col_oe    = col_oe_ff;
  assign digit_sel = col_idx_ff;
  assign key_flag  = key_flag_ff;
  assign key_valid = key_valid_ff;
  assign key_down  = key_down_ff;
  assign key_code  = key_code_ff;
  assign key_col   = key_col_ff;
endmodule : keyboard_matrix_scanner
`default_nettype wire

// ==== design/keyboard_matrix_scanner_defs.svh ====
// Timing, size and code constants for the keyboard matrix scanner
`ifndef KEYBOARD_MATRIX_SCANNER_DEFS_SVH
`define KEYBOARD_MATRIX_SCANNER_DEFS_SVH

`define KMS_CLK_HZ         200000000
`define KMS_SCAN_RATE_HZ   100
`define KMS_NUM_COLS       8
`define KMS_NUM_ROWS       4
`define KMS_DEBOUNCE_SCANS 3
`define KMS_CODE_NONE      4'h0
`define KMS_CODE_MULTI     4'hf
`define KMS_CODE_POS1      4'h1
`define KMS_CODE_POS2      4'h2
`define KMS_CODE_POS3      4'h3
`define KMS_CODE_POS4      4'h4
`define KMS_ROW_BIT0       4'h1
`define KMS_ROW_BIT1       4'h2
`define KMS_ROW_BIT2       4'h4
`define KMS_ROW_BIT3       4'h8

`endif

// ==== design/keyboard_matrix_scanner_pkg.sv ====
// Types shared by the keyboard matrix scanner modules
package keyboard_matrix_scanner_pkg;
  typedef logic [3:0] key_code_t;
  typedef enum logic [0:0] {ST_PROBE, ST_SCAN} scan_state_e;
endpackage : keyboard_matrix_scanner_pkg

// ==== sim/key_matrix.sv ====
// Passive switch matrix: pulled-up rows, open-drain columns
`timescale 1ns/1ps
`default_nettype none
module key_matrix #(parameter int unsigned N_COLS = 4)
(
  input  wire logic [N_COLS-1:0] col_oe,
  input  wire logic [3:0]        press [N_COLS],
  output var  logic [3:0]        row_n
);
  logic [3:0]        row_lo;
  logic [N_COLS-1:0] col_lo;
  // Second pass lets a shorted pair pull the released column low
  always_comb
  begin
    row_lo = 4'h0;
    row_n  = 4'hf;
    for (int c = 0; c < N_COLS; c++)
      row_lo |= col_oe[c] ? press[c] : 4'h0;
    for (int c = 0; c < N_COLS; c++)
      col_lo[c] = col_oe[c] | (|(press[c] & row_lo));
    for (int c = 0; c < N_COLS; c++)
      row_n &= col_lo[c] ? ~press[c] : 4'hf;
  end
endmodule : key_matrix
`default_nettype wire

// ==== sim/keyboard_matrix_scanner_sva.sv ====
// Port assertions for the keyboard matrix scanner
`timescale 1ns/1ps
`default_nettype none
module keyboard_matrix_scanner_sva
  import keyboard_matrix_scanner_pkg::*;
#(parameter int unsigned N_COLS = 8, parameter int unsigned COL_W = 3)
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              scan_en,
  input wire logic [N_COLS-1:0] col_oe,
  input wire logic [COL_W-1:0]  digit_sel,
  input wire logic              key_valid,
  input wire logic              key_down,
  input wire key_code_t         key_code,
  input wire logic [COL_W-1:0]  key_col
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  localparam logic [N_COLS-1:0] all_hi = '1;
  // Holds for the four-cycle dwell the bench sets or any longer dwell
  sequence s_sel_holds;
    $stable(digit_sel) [*3];
  endsequence
  a_one_col_low: assert property (col_oe != all_hi |-> $onehot(col_oe))
    else $error("column drive not one-hot");
  a_sel_matches: assert property (col_oe != all_hi |-> col_oe == (N_COLS'(1) << digit_sel))
    else $error("digit select off column");
  a_sel_steps: assert property ($changed(digit_sel) && digit_sel != 0 |->
    digit_sel == $past(digit_sel) + 1'b1) else $error("column skipped");
  a_sel_stands: assert property (disable iff (!rst_n || !scan_en)
    $changed(digit_sel) |=> s_sel_holds) else $error("column dwell short");
  a_off_all_low: assert property (!scan_en |=> col_oe == all_hi) else $error("not all low");
  a_valid_pulse: assert property (key_valid |=> !key_valid) else $error("long pulse");
  a_valid_key: assert property (key_valid |-> key_down && key_code != 4'h0 &&
    key_col == $past(digit_sel)) else $error("bad accepted key");
  a_reset_idle: assert property ($rose(rst_n) |-> col_oe == all_hi && !key_down &&
    key_code == 4'h0) else $error("not idle after reset");
endmodule : keyboard_matrix_scanner_sva
bind keyboard_matrix_scanner keyboard_matrix_scanner_sva #(.N_COLS(N_COLS), .COL_W(COL_W)) chk
  (.ref_clk(ref_clk), .rst_n(rst_n), .scan_en(scan_en), .col_oe(col_oe), .digit_sel(digit_sel),
   .key_valid(key_valid), .key_down(key_down), .key_code(key_code), .key_col(key_col));
`default_nettype wire

// ==== sim/keyboard_matrix_scanner_tb.sv ====
// Self-checking bench for the keyboard matrix scanner
`timescale 1ns/1ps
`default_nettype none
module keyboard_matrix_scanner_tb;
  import keyboard_matrix_scanner_pkg::*;
  localparam int NC = 4;
  localparam int SC = 16;
  logic          ref_clk, rst_n, scan_en, precoded_en, key_flag, key_valid, key_down;
  logic [3:0]    row_n, m, press [NC];
  logic [NC-1:0] col_oe;
  logic [1:0]    digit_sel, key_col;
  key_code_t     key_code;
  logic [31:0]   seed = 32'h0000d269;
  logic [7:0]    exp_word;
  logic [5:0]    exp_q [$];
  int            miscompares, total_checks, n;
  key_matrix #(.N_COLS(NC)) matrix (.col_oe(col_oe), .press(press), .row_n(row_n));
  keyboard_matrix_scanner #(.N_COLS(NC), .SCAN_CYCLES(SC)) DUT (.ref_clk(ref_clk),
    .rst_n(rst_n), .scan_en(scan_en), .precoded_en(precoded_en), .row_n(row_n),
    .col_oe(col_oe), .digit_sel(digit_sel), .key_flag(key_flag), .key_valid(key_valid),
    .key_down(key_down), .key_code(key_code), .key_col(key_col));
  function automatic logic [3:0] enc(input logic [3:0] r);
    case (r)
      4'h0, 4'h1, 4'h2: return r;
      4'h4: return 4'h3;
      4'h8: return 4'h4;
      default: return 4'hf;
    endcase
  endfunction : enc
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Extra keys go on the next column, so a shorted pair starts in one scan
  task automatic hit(input int col, input logic [3:0] keys, input logic [3:0] extra);
    @(negedge ref_clk);
    press[col] = keys;
    press[(col + 1) % NC] = extra;
    exp_q.push_back({2'(col), precoded_en ? keys :
      enc(keys | ((extra & keys) != 4'h0 ? extra : 4'h0))});
    for (n = 0; n < 400 && key_valid !== 1'b1; n++)
      @(negedge ref_clk);
    check("debounce_wait", 8'(n >= 2 * SC && key_valid === 1'b1), 8'h1);
    press = '{default: 4'h0};
    for (n = 0; n < 400 && key_down !== 1'b0; n++)
      @(negedge ref_clk);
    check("key_release", {7'h0, key_down}, 8'h0);
  endtask : hit
  // Sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge ref_clk)
    if (key_valid === 1'b1)
    begin
      exp_word = exp_q.size() > 0 ? {2'h0, exp_q.pop_front()} : 8'hff;
      check("key_col_code", {2'h0, key_col, key_code}, exp_word);
    end
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #20000;
    miscompares++;
    close_out();
  end
  initial
  begin
    {rst_n, scan_en, precoded_en} = 3'b010;
    press = '{default: 4'h0};
    repeat (4) @(negedge ref_clk);
    check("reset_state", {col_oe, key_code}, 8'hf0);
    check("reset_outputs", {1'b0, key_flag, key_valid, key_down, digit_sel, key_col}, 8'h00);
    rst_n = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      seed = xs(seed);
      m = i < 4 ? 4'h1 << i : i == 4 ? 4'hc : seed[7:4] | 4'h1;
      hit(i < 5 ? i % NC : seed % NC, m, 4'h0);
    end
    hit(0, 4'h1, 4'h3);
    precoded_en = 1'b1;
    hit(0, 4'h5, 4'h0);
    precoded_en = 1'b0;
    // Two scans of history on column 1; the reset must throw it away
    press[1] = 4'h2;
    repeat (30) @(negedge ref_clk);
    rst_n = 1'b0;
    @(negedge ref_clk);
    check("mid_reset", {col_oe, 1'b0, key_flag, key_valid, key_down}, 8'hf0);
    rst_n = 1'b1;
    hit(1, 4'h2, 4'h0);
    scan_en = 1'b0;
    press[2] = 4'h2;
    repeat (4) @(negedge ref_clk);
    check("disabled_cols", {col_oe, 3'h0, key_flag}, 8'hf1);
    close_out();
  end
endmodule : keyboard_matrix_scanner_tb
`default_nettype wire
